/* File: dv/ssp_assertions.sv */
// Checker watching the ports of the serial port core.
// Assumes it is bound to ssp_top; RST resets both domains.
`timescale 1ns/1ps
module ssp_assertions #(
  parameter int RXTO_CYCLES = 32
) (
  // System side
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic IRQ,
  // Link side
  input wire logic LINK_CLK,
  input wire logic TX_OE,
  input wire logic FSS_IN,
  input wire logic FSS_OUT,
  input wire logic FSS_OE
);
  wire logic req = AVS_READ || AVS_WRITE;
  wait_one_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("no answer");
  wait_pulse_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long answer");
  answer_cause_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    $fell(AVS_WAITREQUEST) |-> $past(req)) else $error("stray answer");
  rd_stable_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    $changed(AVS_READDATA) |-> !AVS_WAITREQUEST) else $error("read data moved");
  rst_quiet_a: assert property (@(posedge SYS_CLK)
    RST |=> AVS_WAITREQUEST && !IRQ && AVS_READDATA == 32'h0) else $error("reset");
  idle_line_a: assert property (@(posedge LINK_CLK) disable iff (RST)
    FSS_OUT && FSS_IN |-> !TX_OE) else $error("drive outside frame");
  frame_min_a: assert property (@(posedge LINK_CLK) disable iff (RST)
    $fell(FSS_OUT) |-> (!FSS_OUT)[*4]) else $error("short frame");
  frame_max_a: assert property (@(posedge LINK_CLK) disable iff (RST)
    $fell(FSS_OUT) |-> ##[4:16] FSS_OUT) else $error("long frame");
  fss_drive_a: assert property (@(posedge LINK_CLK) disable iff (RST)
    !FSS_OUT && FSS_OE |-> TX_OE) else $error("master not driving");
  cover property (@(posedge LINK_CLK) $fell(FSS_OUT));
  cover property (@(posedge LINK_CLK) TX_OE && !FSS_IN);
  cover property (@(posedge SYS_CLK) $rose(IRQ));
endmodule // ssp_assertions

bind ssp_top ssp_assertions #(.RXTO_CYCLES(RXTO_CYCLES)) i_chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .LINK_CLK(LINK_CLK), .TX_OE(TX_OE),
  .FSS_IN(FSS_IN), .FSS_OUT(FSS_OUT), .FSS_OE(FSS_OE));

/* File: dv/ssp_peer.sv */
// Serial peripheral that answers each bit with its inverse.
// Assumes an active-low select and sampling on the falling edge.
`timescale 1ns/1ps
module ssp_peer (
  // Link
  input wire logic link_clk,
  input wire logic sel_n,
  input wire logic din,
  // Answer
  output logic dout
);
  // Unselected, the line toggles so a stale bit is never mistaken for data.
  initial dout = 1'b0;
  always @(negedge link_clk) begin
    if (!sel_n) begin
      dout <= ~din;
    end else begin
      dout <= ~dout;
    end
  end
endmodule // ssp_peer

/* File: dv/sync_serial_fifo_irq_port_test.sv */
// Self-checking bench of the serial port core with a looping peer.
// Assumes the package, core, peer and checker are compiled first.
`timescale 1ns/1ps
module sync_serial_fifo_irq_port_test;
  import ssp_pkg::*;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, fin = 1'b1;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, d, mk;
  logic wreq, irq, rxd, txd, txoe, fout, foe, oe_seen;
  logic [63:0] q[$];
  logic [63:0] e;
  logic [31:0] w[9];
  int err_total = 0;
  int checks_done = 0;
  int seed = 12504;
  initial forever #25 clk = ~clk;
  initial begin
    #7;
    forever #15 lclk = ~lclk;
  end
  ssp_top #(.RXTO_CYCLES(4)) i_dut (.SYS_CLK(clk), .RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .IRQ(irq), .LINK_CLK(lclk), .RX_DATA(rxd), .TX_DATA(txd),
    .TX_OE(txoe), .FSS_IN(fin), .FSS_OUT(fout), .FSS_OE(foe));
  ssp_peer i_peer (.link_clk(lclk), .sel_n(fout), .din(txd), .dout(rxd));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [4:0] a, input logic [31:0] v, input logic rnw);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= v;
    rd <= rnw;
    wr <= !rnw;
    do @(posedge clk); while (wreq !== 1'b0 && ++n < 50);
    if (n >= 50) err_total++;
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v);
    q.push_back({m, v & m});
    bus(a, 32'h0, 1'b1);
  endtask
  task automatic wrt(input logic [4:0] a, input logic [31:0] v);
    bus(a, v, 1'b0);
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do rdc(OFS_STAT, 32'h0, 32'h0); while ((d & m) !== v && ++n < 200);
    if (n >= 200) err_total++;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) if (rd && wreq === 1'b0) begin
    if (q.size() == 0) err_total++;
    else begin
      e = q.pop_front();
      if (e[63:32] !== 32'h0) cmp(rdat & e[63:32], e[31:0]);
    end
  end
  always @(posedge lclk) if (txoe === 1'b1) oe_seen = 1'b1;
  initial begin
    #2000000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_CTRL, ALL, 32'h0f0);
    rdc(OFS_STAT, ALL, 32'h5);
    rdc(OFS_IRQST, ALL, 32'h1);
    rdc(5'h18, ALL, 32'h0);
    rdc(OFS_DATA, ALL, 32'h0);
    wrt(OFS_CTRL, 32'h0);
    rdc(OFS_CTRL, ALL, 32'h030);
    for (int n = 4; n <= 16; n += 6) begin
      mk = (32'h1 << n) - 32'h1;
      w[0] = $random(seed);
      wrt(OFS_CTRL, 32'((n - 1) << 4));
      wrt(OFS_DATA, w[0]);
      repeat (20) @(posedge clk);
      rdc(OFS_STAT, ALL, 32'h1);
      wrt(OFS_CTRL, 32'((n - 1) << 4) | 32'h1);
      poll(32'h2, 32'h2);
      rdc(OFS_DATA, mk, ~w[0]);
    end
    for (int m = 1; m <= 2; m++) begin
      oe_seen = 1'b0;
      wrt(OFS_CTRL, 32'h0f1 | 32'(m << 1));
      wrt(OFS_DATA, $random(seed));
      @(posedge lclk) fin <= 1'b0;
      repeat (30) @(posedge lclk);
      fin <= 1'b1;
      cmp({31'h0, oe_seen}, 32'(m == 1));
      poll(32'h2, 32'h2);
      rdc(OFS_DATA, 32'h0, 32'h0);
    end
    wrt(OFS_CTRL, 32'h0b0);
    for (int i = 0; i < 9; i++) begin
      w[i] = $random(seed);
      wrt(OFS_DATA, w[i]);
    end
    rdc(OFS_STAT, ALL, 32'h0);
    wrt(OFS_CTRL, 32'h0b1);
    poll(32'h18, 32'h08);
    rdc(OFS_STAT, ALL, 32'hf);
    rdc(OFS_IRQST, ALL, 32'h7);
    wrt(OFS_DATA, w[8]);
    poll(32'h14, 32'h04);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) rdc(OFS_DATA, 32'hfff, ~w[i]);
    rdc(OFS_DATA, ALL, 32'h0);
    rdc(OFS_IRQST, ALL, 32'hd);
    wrt(OFS_IRQEN, 32'h8);
    repeat (3) @(posedge clk);
    cmp({31'h0, irq}, 32'h1);
    wrt(OFS_CTRL, 32'h0b8);
    rdc(OFS_IRQST, ALL, 32'h8);
    wrt(OFS_IRQCLR, 32'hf);
    wrt(OFS_CTRL, 32'h0b0);
    rdc(OFS_IRQST, ALL, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    conclude();
  end
endmodule // sync_serial_fifo_irq_port_test

/* File: src/ssp_pkg.sv */
// Shared constants and types of the synchronous serial port core.
// Assumes one system clock for the register side and one link clock at the pins.
package ssp_pkg;

  // ********************************************************************
  // Sizes and timing
  // ********************************************************************
  localparam int DATA_W = 16;
  localparam int DEPTH = 8;
  localparam logic [3:0] DEPTH_CNT = 4'h8;
  localparam logic [3:0] SVC_LEVEL = 4'h4;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RXTO_NS = 1600;
  localparam int RXTO_CYC = (RXTO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ********************************************************************
  // Register byte offsets and fields
  // ********************************************************************
  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_CTRL = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_IRQEN = 5'h0c;
  localparam logic [4:0] OFS_IRQST = 5'h10;
  localparam logic [4:0] OFS_IRQCLR = 5'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MSEL_BIT = 3;
  localparam int CTRL_WID_LSB = 4;
  localparam int CTRL_FMT_LSB = 8;
  localparam logic [3:0] WID_RST = 4'hf;
  localparam logic [3:0] WID_MIN = 4'h3;
  localparam int IRQ_TXFF = 0;
  localparam int IRQ_RXFF = 1;
  localparam int IRQ_RXTO = 2;
  localparam int IRQ_RXOR = 3;

  // ********************************************************************
  // Modes, states and carriers
  // ********************************************************************
  localparam logic [1:0] MODE_MASTER = 2'h0;
  localparam logic [1:0] MODE_SLAVE = 2'h1;
  localparam logic [1:0] MODE_SLAVE_OD = 2'h2;

  typedef enum logic [1:0] {LK_IDLE = 2'b01, LK_SHIFT = 2'b10} ssp_lstate_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] wid;
    logic [DATA_W-1:0] data;
  } ssp_frame_t;

  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic irq;
    logic en;
    logic [1:0] mode;
    logic msel;
    logic [3:0] wid;
    logic [3:0] fmt;
    logic [3:0] ien;
    logic rxto;
    logic rxor;
    logic [DEPTH-1:0][DATA_W-1:0] txm;
    logic [DEPTH-1:0][DATA_W-1:0] rxm;
    logic [2:0] txwp;
    logic [2:0] txrp;
    logic [3:0] txcnt;
    logic [2:0] rxwp;
    logic [2:0] rxrp;
    logic [3:0] rxcnt;
    logic pend;
    logic txr;
    logic rxs1;
    logic rxs2;
    logic rxseen;
    ssp_frame_t frame;
    logic [5:0] tcnt;
  } ssp_sys_t;

  typedef struct packed {
    logic rs1;
    logic rs2;
    ssp_lstate_t st;
    logic [DATA_W-1:0] sh;
    logic [3:0] cnt;
    logic [1:0] mode;
    logic [DATA_W-1:0] rx_word;
    logic rxt;
    logic txs1;
    logic txs2;
    logic txseen;
    logic fss;
    logic fss_oe;
    logic tx_oe;
  } ssp_link_t;

endpackage

/* File: src/ssp_top.sv */
// Synchronous serial port core: register slave, FIFOs, interrupt status, link shifter.
// Assumes an Avalon-MM master on SYS_CLK and a free-running LINK_CLK at the pins.
//
// Behaviour
// - A transmit write keeps only the low N frame-width bits and drops the rest.
// - A receive read returns valid data only in its low N bits, upper bits zero.
// - Four interrupt sources form one field: tx service, rx service, rx timeout, overrun.
// - Each source has its own enable and only enabled sources drive the interrupt.
// - Software can read the raw status or the status ANDed with the enables.
// - A clear mask write deasserts rx timeout and/or overrun, the only clearable ones.
// - Clearing the enable stops new frames from launching, letting a running one finish; setting it resumes them.
// - A receive-not-empty flag tells software whether a word can be read.
// - A transmit-not-full flag tells software whether a word can be written.
// - Transmit and receive each have an independent eight-entry 16-bit FIFO.
// - The frame width is programmable from 4 to 16 bits inclusive.
// - Master or slave operation, with a slave mode that never drives the data line.
`timescale 1ns/1ps
module ssp_top #(
  parameter int RXTO_CYCLES = ssp_pkg::RXTO_CYC
) (
  // System side
  input wire logic SYS_CLK,
  input wire logic RST,
  // Avalon-MM register slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Interrupt
  output logic IRQ,
  // Serial link
  input wire logic LINK_CLK,
  input wire logic RX_DATA,
  output logic TX_DATA,
  output logic TX_OE,
  input wire logic FSS_IN,
  output logic FSS_OUT,
  output logic FSS_OE
);
  import ssp_pkg::*;

  ssp_sys_t s_q;
  ssp_sys_t s_d;
  ssp_link_t l_q;
  ssp_link_t l_d;

  function automatic logic [DATA_W-1:0] trim(input logic [31:0] v, input logic [3:0] w);
    logic [16:0] m;
    m = (17'h1 << ({1'b0, w} + 5'h1)) - 17'h1;
    return v[DATA_W-1:0] & m[DATA_W-1:0];
  endfunction

  // ********************************************************************
  // System domain
  // ********************************************************************
  logic [3:0] raw;
  logic req;
  logic acc;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic done;
  logic [3:0] wid_wr;

  always_comb begin
    raw = 4'h0;
    raw[IRQ_TXFF] = s_q.txcnt <= SVC_LEVEL;
    raw[IRQ_RXFF] = s_q.rxcnt >= SVC_LEVEL;
    raw[IRQ_RXTO] = s_q.rxto;
    raw[IRQ_RXOR] = s_q.rxor;
  end

  always_comb begin
    s_d = s_q;
    req = AVS_READ | AVS_WRITE;
    acc = req & ~s_q.wreq;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    wid_wr = AVS_WRITEDATA[CTRL_WID_LSB +: 4];
    done = s_q.rxs2 != s_q.rxseen;
    // One wait cycle per access: waitrequest drops for exactly the accepting edge.
    s_d.wreq = ~(req & s_q.wreq);
    if (req & s_q.wreq & AVS_READ) begin
      unique case (AVS_ADDRESS)
        OFS_DATA: s_d.rdata = (s_q.rxcnt == 4'h0) ? 32'h0 : {16'h0, s_q.rxm[s_q.rxrp]};
        OFS_CTRL: s_d.rdata = {20'h0, s_q.fmt, s_q.wid, s_q.msel, s_q.mode, s_q.en};
        OFS_STAT: s_d.rdata = {27'h0, s_q.pend, s_q.rxcnt == DEPTH_CNT, s_q.txcnt == 4'h0,
                               s_q.rxcnt != 4'h0, s_q.txcnt != DEPTH_CNT};
        OFS_IRQEN: s_d.rdata = {28'h0, s_q.ien};
        OFS_IRQST: s_d.rdata = {28'h0, s_q.msel ? (raw & s_q.ien) : raw};
        default: s_d.rdata = 32'h0;
      endcase
    end
    // The clear is applied first so that an event in the same cycle still sets the flag.
    if (acc & AVS_WRITE) begin
      unique case (AVS_ADDRESS)
        OFS_DATA: tx_push = s_q.txcnt != DEPTH_CNT;
        OFS_CTRL: begin
          s_d.en = AVS_WRITEDATA[CTRL_EN_BIT];
          s_d.mode = AVS_WRITEDATA[CTRL_MODE_LSB +: 2];
          s_d.msel = AVS_WRITEDATA[CTRL_MSEL_BIT];
          s_d.wid = (wid_wr < WID_MIN) ? WID_MIN : wid_wr;
          s_d.fmt = AVS_WRITEDATA[CTRL_FMT_LSB +: 4];
        end
        OFS_IRQEN: s_d.ien = AVS_WRITEDATA[3:0];
        OFS_IRQCLR: begin
          if (AVS_WRITEDATA[IRQ_RXTO]) begin
            s_d.rxto = 1'b0;
          end
          if (AVS_WRITEDATA[IRQ_RXOR]) begin
            s_d.rxor = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (acc & AVS_READ & (AVS_ADDRESS == OFS_DATA)) begin
      rx_pop = s_q.rxcnt != 4'h0;
    end
    if (tx_push) begin
      s_d.txm[s_q.txwp] = trim(AVS_WRITEDATA, s_q.wid);
      s_d.txwp = s_q.txwp + 3'h1;
    end
    // A new frame is launched only while enabled; a running frame is allowed to finish.
    if (s_q.en & ~s_q.pend & (s_q.txcnt != 4'h0)) begin
      tx_pop = 1'b1;
      s_d.frame = '{mode: s_q.mode, wid: s_q.wid, data: s_q.txm[s_q.txrp]};
      s_d.txrp = s_q.txrp + 3'h1;
      s_d.pend = 1'b1;
      s_d.txr = ~s_q.txr;
    end
    s_d.txcnt = s_q.txcnt + {3'h0, tx_push} - {3'h0, tx_pop};
    s_d.rxs1 = l_q.rxt;
    s_d.rxs2 = s_q.rxs1;
    if (done) begin
      s_d.rxseen = s_q.rxs2;
      s_d.pend = 1'b0;
      if (s_q.rxcnt == DEPTH_CNT) begin
        s_d.rxor = 1'b1;
      end else begin
        rx_push = 1'b1;
      end
    end
    if (rx_push) begin
      s_d.rxm[s_q.rxwp] = trim({16'h0, l_q.rx_word}, s_q.frame.wid);
      s_d.rxwp = s_q.rxwp + 3'h1;
    end
    if (rx_pop) begin
      s_d.rxrp = s_q.rxrp + 3'h1;
    end
    s_d.rxcnt = s_q.rxcnt + {3'h0, rx_push} - {3'h0, rx_pop};
    // Timeout: words waiting in the rx FIFO with no new frame for the timeout span.
    if ((s_q.rxcnt == 4'h0) | rx_push) begin
      s_d.tcnt = 6'h0;
    end else if (s_q.tcnt != RXTO_CYCLES[5:0]) begin
      s_d.tcnt = s_q.tcnt + 6'h1;
      if (s_q.tcnt == RXTO_CYCLES[5:0] - 6'h1) begin
        s_d.rxto = 1'b1;
      end
    end
    s_d.irq = |(raw & s_q.ien);
    if (RST) begin
      s_d = '0;
      s_d.wreq = 1'b1;
      s_d.wid = WID_RST;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    s_q <= s_d;
  end

  // ********************************************************************
  // Link domain
  // ********************************************************************
  // The frame word is held still by the system side until the done toggle returns,
  // so the link side may read it directly once the request toggle is synchronised.
  always_comb begin
    l_d = l_q;
    l_d.rs1 = RST;
    l_d.rs2 = l_q.rs1;
    l_d.txs1 = s_q.txr;
    l_d.txs2 = l_q.txs1;
    unique case (l_q.st)
      LK_IDLE: begin
        l_d.tx_oe = 1'b0;
        l_d.fss = 1'b1;
        l_d.fss_oe = l_q.mode == MODE_MASTER;
        if ((l_q.txs2 != l_q.txseen) &
            ((s_q.frame.mode == MODE_MASTER) | ~FSS_IN)) begin
          l_d.txseen = l_q.txs2;
          l_d.mode = s_q.frame.mode;
          l_d.sh = s_q.frame.data << (4'hf - s_q.frame.wid);
          l_d.cnt = s_q.frame.wid;
          l_d.st = LK_SHIFT;
          l_d.fss = 1'b0;
          l_d.fss_oe = s_q.frame.mode == MODE_MASTER;
          l_d.tx_oe = s_q.frame.mode != MODE_SLAVE_OD;
        end
      end
      LK_SHIFT: begin
        l_d.sh = {l_q.sh[DATA_W-2:0], RX_DATA};
        if (l_q.cnt == 4'h0) begin
          l_d.rx_word = {l_q.sh[DATA_W-2:0], RX_DATA};
          l_d.rxt = ~l_q.rxt;
          l_d.st = LK_IDLE;
          l_d.fss = 1'b1;
          l_d.tx_oe = 1'b0;
        end else begin
          l_d.cnt = l_q.cnt - 4'h1;
        end
      end
      default: l_d.st = LK_IDLE;
    endcase
    if (l_q.rs2) begin
      l_d = '0;
      l_d.rs1 = RST;
      l_d.rs2 = l_q.rs1;
      l_d.st = LK_IDLE;
      l_d.fss = 1'b1;
      l_d.fss_oe = 1'b1;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    l_q <= l_d;
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign AVS_READDATA = s_q.rdata;
  assign AVS_WAITREQUEST = s_q.wreq;
  assign IRQ = s_q.irq;
  assign TX_DATA = l_q.sh[DATA_W-1];
  assign TX_OE = l_q.tx_oe;
  assign FSS_OUT = l_q.fss;
  assign FSS_OE = l_q.fss_oe;

endmodule // ssp_top
